// >>> include/prog_port_defs.vh
// Constants for the nonvolatile memory programming port
`ifndef PROG_PORT_DEFS_VH
`define PROG_PORT_DEFS_VH

`define CLK_MHZ 20
`define T_WRITE_MIN_US 3700
`define T_ERASE_MIN_US 7500

`define ERASED_BYTE 8'hFF
`define ERASED_WORD 16'hFFFF
`define FUSE_RST 8'hFF
`define LOCK_RST 8'hFF

`define ACT_ADDR 2'h0
`define ACT_CMD 2'h2
`define PCMD_SIG 8'h08
`define PCMD_ERASE 8'h80
`define PCMD_FLASH_WR 8'h10
`define PCMD_EE_WR 8'h11
`define PCMD_FUSE_WR 8'h40
`define PCMD_LOCK_WR 8'h20

`define SI_ESC 8'hAC
`define SI_ENABLE_B2 8'h53
`define SI_ERASE_B2 3'h4
`define SI_LOCK_B2 3'h7
`define SI_FUSE_LO_B2 8'hA0
`define SI_FUSE_HI_B2 8'hA8
`define SI_FUSE_EXT_B2 8'hA4
`define SI_RD_FLASH_LO 8'h20
`define SI_RD_FLASH_HI 8'h28
`define SI_LD_LO 8'h40
`define SI_LD_HI 8'h48
`define SI_WR_PAGE 8'h4C
`define SI_RD_EE 8'hA0
`define SI_WR_EE 8'hC0
`define SI_RD_LOCK_FHI 8'h58
`define SI_RD_FUSE 8'h50
`define SI_HI_SEL 8'h08
`define SI_RD_SIG 8'h30
`define SI_RD_CAL 8'h38

`endif

// >>> logic/stream_fifo.v
// Word FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk_in,
    input wire nrst_in,
    input wire in_valid_in,
    input wire [WIDTH-1:0] in_data_in,
    output wire in_ready_out,
    output wire out_valid_out,
    output wire [WIDTH-1:0] out_data_out,
    input wire out_ready_in
);
    localparam [AW:0] FULL = DEPTH;
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push = in_valid_in & (cnt_q != FULL);
    wire pop = out_ready_in & (cnt_q != {(AW+1){1'b0}});

    assign in_ready_out = (cnt_q != FULL);
    assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
    assign out_data_out = mem[rd_q];

    always @(posedge clk_in) begin
        if (push) begin
            mem[wr_q] <= in_data_in;
        end
    end

    // Depth must be a power of two so the pointers wrap naturally
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // stream_fifo
`default_nettype wire

// >>> logic/memory_programming_port.v
// Serial programming port for program and data nonvolatile memory; parallel mode only erases, reads signature and calibration bytes and runs write busy timing
`timescale 1ns/1ps
`default_nettype none
`include "prog_port_defs.vh"
module memory_programming_port #(
    parameter FLASH_AW = 16,
    parameter EE_AW = 12,
    parameter PAGE_AW = 7,
    parameter FIFO_DEPTH = 8,
    parameter [17:0] WRITE_CYCLES = `T_WRITE_MIN_US * `CLK_MHZ,
    parameter [17:0] ERASE_CYCLES = `T_ERASE_MIN_US * `CLK_MHZ,
    parameter [23:0] SIG_BYTES = 24'h3C_A5_5A, // Arbitrary value
    parameter [31:0] CAL_BYTES = 32'h80_80_80_80
) (
    input wire clk_in,
    input wire nrst_in,
    input wire reset_pin_n_in,
    input wire program_entry_pin_n_in,
    input wire serial_clock_in,
    input wire prog_serial_in,
    input wire par_mode_in,
    input wire [1:0] load_action_select_in,
    input wire byte_half_select_in,
    input wire load_strobe_clock_in,
    input wire write_strobe_n_in,
    input wire read_drive_n_in,
    input wire [7:0] par_data_in,
    output reg [7:0] par_data_out,
    output reg par_data_oe_out,
    output reg ready_busy_flag_out,
    output reg prog_serial_out,
    output reg prog_serial_oe_out,
    output reg prog_mode_out
);
    localparam S_IDLE = 4'b0001;
    localparam S_COPY = 4'b0010;
    localparam S_ERASE = 4'b0100;
    localparam S_WAIT = 4'b1000;

    // Two-flop synchronisers on every pin
    reg [18:0] sync1_q;
    reg [18:0] sync2_q;
    reg [2:0] prev_q;
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_q <= 19'h0;
            sync2_q <= 19'h0;
            prev_q <= 3'h0;
        end else begin
            sync1_q <= {serial_clock_in, prog_serial_in, reset_pin_n_in, program_entry_pin_n_in,
                        par_mode_in, load_action_select_in, byte_half_select_in,
                        load_strobe_clock_in, write_strobe_n_in, read_drive_n_in, par_data_in};
            sync2_q <= sync1_q;
            prev_q <= {sync2_q[18], sync2_q[10], sync2_q[9]};
        end
    end
    wire sck_s = sync2_q[18];
    wire ser_din_s = sync2_q[17];
    wire rst_pin_n_s = sync2_q[16];
    wire entry_n_s = sync2_q[15];
    wire par_s = sync2_q[14];
    wire [1:0] xa_s = sync2_q[13:12];
    wire half_sel_s = sync2_q[11];
    wire xtal_s = sync2_q[10];
    wire wr_n_s = sync2_q[9];
    wire oe_n_s = sync2_q[8];
    wire [7:0] pdata_s = sync2_q[7:0];
    wire sck_rise = sck_s & ~prev_q[2];
    wire sck_fall = ~sck_s & prev_q[2];
    wire xtal_rise = xtal_s & ~prev_q[1];
    wire wr_fall = ~wr_n_s & prev_q[0];

    // Entry pin is a strap, caught once the synchroniser holds a settled level
    reg [1:0] init_q;
    reg entry_mode_q;
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            init_q <= 2'h0;
            entry_mode_q <= 1'b0;
        end else if (init_q != 2'h3) begin
            init_q <= init_q + 1'b1;
            if (init_q == 2'h2) begin
                entry_mode_q <= ~entry_n_s & ~sck_s;
            end
        end
    end
    wire ser_mode = (init_q == 2'h3) & (~rst_pin_n_s | entry_mode_q) & ~par_s;

    // Memories and nonvolatile configuration bytes
    reg [15:0] flash_mem [0:(1<<FLASH_AW)-1];
    reg [7:0] ee_mem [0:(1<<EE_AW)-1];
    reg [15:0] page_buf [0:(1<<PAGE_AW)-1];
    reg [7:0] fuse_lo_q;
    reg [7:0] fuse_hi_q;
    reg [7:0] fuse_ext_q;
    reg [7:0] lock_q;
    reg [3:0] st_q;
    reg [17:0] cnt_q;
    reg op_flash_q;
    reg op_erase_q;
    reg [FLASH_AW-PAGE_AW-1:0] page_q;

    // Serial framing
    reg [2:0] bit_q;
    reg [1:0] byte_q;
    reg [7:0] rx_q;
    reg [7:0] b1_q;
    reg [7:0] b2_q;
    reg [7:0] tx_q;
    reg prog_en_q;
    reg pend_valid_q;
    reg [31:0] pend_q;
    wire [7:0] rx_byte = {rx_q[6:0], ser_din_s};
    wire [15:0] rd_faddr = {b2_q, rx_byte};
    wire [FLASH_AW-1:0] rd_fa = rd_faddr[FLASH_AW-1:0];
    wire [15:0] rd_fword = flash_mem[rd_fa];
    wire [11:0] rd_ea_full = {b2_q[3:0], rx_byte};
    wire [EE_AW-1:0] rd_ea = rd_ea_full[EE_AW-1:0];
    wire rd_fbusy = op_erase_q | (op_flash_q & (rd_fa[FLASH_AW-1:PAGE_AW] == page_q));
    reg [7:0] rd_data;
    reg is_read;

    // Read answer for byte four, decided as byte three completes
    always @* begin
        rd_data = `ERASED_BYTE;
        is_read = 1'b1;
        case (b1_q)
            `SI_RD_FLASH_LO: rd_data = rd_fbusy ? `ERASED_BYTE : rd_fword[7:0];
            `SI_RD_FLASH_HI: rd_data = rd_fbusy ? `ERASED_BYTE : rd_fword[15:8];
            `SI_RD_EE: rd_data = op_erase_q ? `ERASED_BYTE : ee_mem[rd_ea];
            `SI_RD_LOCK_FHI: rd_data = (b2_q == `SI_HI_SEL) ? fuse_hi_q : lock_q;
            `SI_RD_FUSE: rd_data = (b2_q == `SI_HI_SEL) ? fuse_ext_q : fuse_lo_q;
            `SI_RD_SIG: rd_data = (rx_byte[1:0] == 2'h3) ? `ERASED_BYTE :
                                  SIG_BYTES[{rx_byte[1:0], 3'h0} +: 8];
            `SI_RD_CAL: rd_data = CAL_BYTES[{rx_byte[1:0], 3'h0} +: 8];
            default: is_read = 1'b0;
        endcase
    end
    wire is_write = (b1_q == `SI_ESC) | (b1_q == `SI_LD_LO) | (b1_q == `SI_LD_HI) |
                    (b1_q == `SI_WR_PAGE) | (b1_q == `SI_WR_EE);

    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [31:0] fifo_out_data;
    wire fifo_pop = (st_q == S_IDLE) & ser_mode;

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bit_q <= 3'h0;
            byte_q <= 2'h0;
            rx_q <= 8'h00;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
            tx_q <= 8'h00;
            prog_en_q <= 1'b0;
            pend_valid_q <= 1'b0;
            pend_q <= 32'h0;
            prog_serial_out <= 1'b0;
        end else if (!ser_mode) begin
            // Leaving serial mode (reset pin high without the strap, or parallel mode) drops sync and enable; a fresh entry restarts framing
            bit_q <= 3'h0;
            byte_q <= 2'h0;
            tx_q <= 8'h00;
            prog_en_q <= 1'b0;
            pend_valid_q <= 1'b0;
            prog_serial_out <= 1'b0;
        end else begin
            if (pend_valid_q & fifo_in_ready) begin
                pend_valid_q <= 1'b0;
            end
            if (sck_rise) begin
                rx_q <= rx_byte;
                bit_q <= bit_q + 1'b1;
                if (bit_q == 3'h7) begin
                    byte_q <= byte_q + 1'b1;
                    if (byte_q == 2'h0) begin
                        b1_q <= rx_byte;
                    end
                    if (byte_q == 2'h1) begin
                        b2_q <= rx_byte;
                    end
                    // Echo the byte just taken; after byte three the read answer goes out
                    if (byte_q == 2'h2 && prog_en_q && is_read) begin
                        tx_q <= rd_data;
                    end else begin
                        tx_q <= rx_byte;
                    end
                    if (byte_q == 2'h2) begin
                        pend_q[15:8] <= rx_byte;
                    end
                    if (byte_q == 2'h3) begin
                        if (b1_q == `SI_ESC && b2_q == `SI_ENABLE_B2) begin
                            prog_en_q <= 1'b1;
                        end else if (prog_en_q && is_write && !pend_valid_q) begin
                            pend_valid_q <= 1'b1;
                            pend_q <= {b1_q, b2_q, pend_q[15:8], rx_byte};
                        end
                    end
                end
            end else if (sck_fall) begin
                prog_serial_out <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    stream_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH),
        .AW(3)
    ) u_cmd_fifo (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .in_valid_in(pend_valid_q),
        .in_data_in(pend_q),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(fifo_pop)
    );

    wire [7:0] c1 = fifo_out_data[31:24];
    wire [7:0] c2 = fifo_out_data[23:16];
    wire [7:0] c3 = fifo_out_data[15:8];
    wire [7:0] c4 = fifo_out_data[7:0];
    wire [11:0] c_ea_full = {c2[3:0], c3};
    wire [EE_AW-1:0] c_ea = c_ea_full[EE_AW-1:0];
    wire [PAGE_AW-1:0] c_word = c3[PAGE_AW-1:0];
    wire [8:0] c_page = {c2, c3[7]};

    // Parallel command and address latches
    reg [7:0] pcmd_q;
    reg [7:0] paddr_q;
    wire par_on = par_s & (init_q == 2'h3);
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pcmd_q <= 8'h00;
            paddr_q <= 8'h00;
        end else if (par_on && xtal_rise) begin
            if (xa_s == `ACT_CMD) begin
                pcmd_q <= pdata_s;
            end else if (xa_s == `ACT_ADDR && !half_sel_s) begin
                paddr_q <= pdata_s;
            end
        end
    end
    wire par_write = (pcmd_q == `PCMD_FLASH_WR) | (pcmd_q == `PCMD_EE_WR) |
                     (pcmd_q == `PCMD_FUSE_WR) | (pcmd_q == `PCMD_LOCK_WR);

    // Memory engine: one write in flight; page copy and erase sweep run one word a cycle
    reg [FLASH_AW-1:0] sweep_q;
    reg [PAGE_AW-1:0] idx_q;
    reg ee_pend_q;
    reg [EE_AW-1:0] ee_addr_q;
    reg [7:0] ee_data_q;
    always @(posedge clk_in) begin
        if (st_q == S_COPY) begin
            flash_mem[{page_q, idx_q}] <= page_buf[idx_q];
        end else if (st_q == S_ERASE) begin
            flash_mem[sweep_q] <= `ERASED_WORD;
            if (sweep_q[FLASH_AW-1:EE_AW] == {(FLASH_AW-EE_AW){1'b0}}) begin
                ee_mem[sweep_q[EE_AW-1:0]] <= `ERASED_BYTE;
            end
        end else if (st_q == S_WAIT && ee_pend_q && cnt_q == 18'h1) begin
            ee_mem[ee_addr_q] <= ee_data_q;
        end else if (fifo_pop && fifo_out_valid) begin
            if (c1 == `SI_LD_LO) begin
                page_buf[c_word] <= {page_buf[c_word][15:8], c4};
            end else if (c1 == `SI_LD_HI) begin
                page_buf[c_word] <= {c4, page_buf[c_word][7:0]};
            end else if (c1 == `SI_WR_EE) begin
                ee_mem[c_ea] <= `ERASED_BYTE;
            end
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q <= S_IDLE;
            cnt_q <= 18'h0;
            op_flash_q <= 1'b0;
            op_erase_q <= 1'b0;
            page_q <= {(FLASH_AW-PAGE_AW){1'b0}};
            sweep_q <= {FLASH_AW{1'b0}};
            idx_q <= {PAGE_AW{1'b0}};
            ee_pend_q <= 1'b0;
            ee_addr_q <= {EE_AW{1'b0}};
            ee_data_q <= 8'h00;
            fuse_lo_q <= `FUSE_RST;
            fuse_hi_q <= `FUSE_RST;
            fuse_ext_q <= `FUSE_RST;
            lock_q <= `LOCK_RST;
            ready_busy_flag_out <= 1'b1;
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (par_on && wr_fall && pcmd_q == `PCMD_ERASE) begin
                        st_q <= S_ERASE;
                        cnt_q <= ERASE_CYCLES;
                        op_erase_q <= 1'b1;
                        sweep_q <= {FLASH_AW{1'b0}};
                        lock_q <= `LOCK_RST;
                        ready_busy_flag_out <= 1'b0;
                    end else if (par_on && wr_fall && par_write) begin
                        st_q <= S_WAIT;
                        cnt_q <= WRITE_CYCLES;
                        ready_busy_flag_out <= 1'b0;
                    end else if (fifo_pop && fifo_out_valid) begin
                        cnt_q <= WRITE_CYCLES;
                        if (c1 == `SI_ESC) begin
                            st_q <= S_WAIT;
                            ready_busy_flag_out <= 1'b0;
                            if (c2[7:5] == `SI_ERASE_B2) begin
                                st_q <= S_ERASE;
                                cnt_q <= ERASE_CYCLES;
                                op_erase_q <= 1'b1;
                                sweep_q <= {FLASH_AW{1'b0}};
                                lock_q <= `LOCK_RST;
                            end else if (c2[7:5] == `SI_LOCK_B2) begin
                                lock_q <= {2'h3, c4[5:0]};
                            end else if (c2 == `SI_FUSE_LO_B2) begin
                                fuse_lo_q <= c4;
                            end else if (c2 == `SI_FUSE_HI_B2) begin
                                fuse_hi_q <= c4;
                            end else if (c2 == `SI_FUSE_EXT_B2) begin
                                fuse_ext_q <= {6'h3F, c4[1:0]};
                            end else begin
                                st_q <= S_IDLE;
                                ready_busy_flag_out <= 1'b1;
                            end
                        end else if (c1 == `SI_WR_PAGE) begin
                            st_q <= S_COPY;
                            op_flash_q <= 1'b1;
                            ready_busy_flag_out <= 1'b0;
                            page_q <= c_page[FLASH_AW-PAGE_AW-1:0];
                            idx_q <= {PAGE_AW{1'b0}};
                        end else if (c1 == `SI_WR_EE) begin
                            st_q <= S_WAIT;
                            ready_busy_flag_out <= 1'b0;
                            ee_pend_q <= 1'b1;
                            ee_addr_q <= c_ea;
                            ee_data_q <= c4;
                        end
                    end
                end
                S_COPY: begin
                    cnt_q <= cnt_q - 1'b1;
                    idx_q <= idx_q + 1'b1;
                    if (idx_q == {PAGE_AW{1'b1}}) begin
                        st_q <= S_WAIT;
                    end
                end
                S_ERASE: begin
                    cnt_q <= cnt_q - 1'b1;
                    sweep_q <= sweep_q + 1'b1;
                    if (sweep_q == {FLASH_AW{1'b1}}) begin
                        st_q <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_q <= 18'h1) begin
                        st_q <= S_IDLE;
                        op_flash_q <= 1'b0;
                        op_erase_q <= 1'b0;
                        ee_pend_q <= 1'b0;
                        ready_busy_flag_out <= 1'b1;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // Parallel read port and mode outputs
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            par_data_out <= 8'h00;
            par_data_oe_out <= 1'b0;
            prog_serial_oe_out <= 1'b0;
            prog_mode_out <= 1'b0;
        end else begin
            par_data_oe_out <= par_on & ~oe_n_s & (pcmd_q == `PCMD_SIG);
            if (half_sel_s) begin
                par_data_out <= CAL_BYTES[{paddr_q[1:0], 3'h0} +: 8];
            end else if (paddr_q[1:0] == 2'h3) begin
                par_data_out <= `ERASED_BYTE;
            end else begin
                par_data_out <= SIG_BYTES[{paddr_q[1:0], 3'h0} +: 8];
            end
            prog_serial_oe_out <= ser_mode;
            prog_mode_out <= ser_mode | par_on;
        end
    end
endmodule // memory_programming_port
`default_nettype wire

// >>> dv/prog_port_monitor.sv
// Pin-level assertions for the programming port
`timescale 1ns/1ps
`default_nettype none
module prog_port_monitor #(
    parameter [17:0] WRITE_CYCLES = 18'h12C,
    parameter [17:0] ERASE_CYCLES = 18'h5DC,
    parameter [23:0] SIG_BYTES = 24'h3CA55A, // Arbitrary value
    parameter [31:0] CAL_BYTES = 32'h80808080
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic serial_clock_in,
    input wire logic par_mode_in,
    input wire logic [1:0] load_action_select_in,
    input wire logic byte_half_select_in,
    input wire logic load_strobe_clock_in,
    input wire logic write_strobe_n_in,
    input wire logic read_drive_n_in,
    input wire logic [7:0] par_data_in,
    input wire logic [7:0] par_data_out,
    input wire logic par_data_oe_out,
    input wire logic ready_busy_flag_out,
    input wire logic prog_serial_out,
    input wire logic prog_serial_oe_out
);
    logic [7:0] cmd_q;
    logic [7:0] addr_q;
    logic [18:0] low_q;
    logic stb_q;
    wire rd = par_mode_in && !read_drive_n_in && cmd_q == 8'h08;
    wire wr = cmd_q inside {8'h10, 8'h11, 8'h40, 8'h20, 8'h80};
    wire [7:0] sig = addr_q[1:0] == 2'h3 ? 8'hFF : SIG_BYTES[8*addr_q[1:0] +: 8];
    wire [7:0] cal = CAL_BYTES[8*addr_q[1:0] +: 8];
    // Captured at the pin edge; the port's synchroniser lags, so windows below allow slack
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_q <= 8'h00;
            addr_q <= 8'h00;
            low_q <= 19'h0;
            stb_q <= 1'b0;
        end else begin
            stb_q <= load_strobe_clock_in;
            low_q <= ready_busy_flag_out ? 19'h0 : low_q + 19'h1;
            if (load_strobe_clock_in && !stb_q && load_action_select_in == 2'h2)
                cmd_q <= par_data_in;
            if (load_strobe_clock_in && !stb_q && load_action_select_in == 2'h0)
                addr_q <= par_data_in;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    a_busy_start: assert property ($fell(write_strobe_n_in) && par_mode_in && wr
        |-> ##[1:20] !ready_busy_flag_out) else $error("busy flag late");
    a_busy_min: assert property ($rose(ready_busy_flag_out)
        |-> low_q >= WRITE_CYCLES - 18'h2) else $error("busy too short");
    a_busy_max: assert property (!ready_busy_flag_out
        |-> low_q < ERASE_CYCLES * 4 / 3 + 8) else $error("busy too long");
    a_busy_hold: assert property ($fell(ready_busy_flag_out)
        |-> !ready_busy_flag_out [*8]) else $error("busy glitch");
    a_par_oe_off: assert property (read_drive_n_in [*6]
        |-> !par_data_oe_out) else $error("data driven without read");
    a_sig_byte: assert property ((rd && !byte_half_select_in) [*6]
        |-> par_data_oe_out && par_data_out == sig) else $error("wrong signature byte");
    a_cal_byte: assert property ((rd && byte_half_select_in) [*6]
        |-> par_data_oe_out && par_data_out == cal) else $error("wrong calibration byte");
    a_serial_edge: assert property (prog_serial_oe_out && $past(prog_serial_oe_out)
        && $changed(prog_serial_out) |-> !$past(serial_clock_in)) else $error("out moved high");
    c_busy: cover property ($rose(ready_busy_flag_out));
    c_cal: cover property (par_data_oe_out && byte_half_select_in);
    c_reply: cover property ($changed(prog_serial_out));
endmodule // prog_port_monitor
bind memory_programming_port prog_port_monitor #(.WRITE_CYCLES(WRITE_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES), .SIG_BYTES(SIG_BYTES), .CAL_BYTES(CAL_BYTES)) i_mon (.*);
`default_nettype wire

// >>> dv/serial_programmer.sv
// Behavioural serial programmer driving the link pins
`timescale 1ns/1ps
`default_nettype none
module serial_programmer (
    input wire logic clk_in,
    input wire logic miso_in,
    output var logic sck_out,
    output var logic mosi_out,
    output var logic done_out,
    output var logic [31:0] rx_out
);
    initial begin
        sck_out = 1'b0;
        mosi_out = 1'b0;
        done_out = 1'b0;
        rx_out = 32'h0;
    end
    // Whole frames only; clock parked low between them
    task automatic frame(input logic [31:0] tx);
        for (int i = 31; i >= 0; i--) begin
            mosi_out <= tx[i];
            repeat (4) @(posedge clk_in);
            sck_out <= 1'b1;
            rx_out[i] <= miso_in;
            repeat (4) @(posedge clk_in);
            sck_out <= 1'b0;
        end
        mosi_out <= ~tx[0];
        done_out <= 1'b1;
        @(posedge clk_in);
        done_out <= 1'b0;
    endtask
endmodule // serial_programmer
`default_nettype wire

// >>> dv/memory_programming_port_test.sv
// Self-checking bench for the programming port
`timescale 1ns/1ps
`default_nettype none
module memory_programming_port_test;
    localparam [23:0] SIG = 24'h3CA55A; // Arbitrary value
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic reset_pin_n_in = 1'b0;
    logic program_entry_pin_n_in = 1'b1;
    logic par_mode_in = 1'b0;
    logic [1:0] load_action_select_in = 2'h0;
    logic byte_half_select_in = 1'b0;
    logic load_strobe_clock_in = 1'b0;
    logic write_strobe_n_in = 1'b1;
    logic read_drive_n_in = 1'b1;
    logic [7:0] par_data_in = 8'h00;
    wire [7:0] par_data_out;
    wire par_data_oe_out, ready_busy_flag_out, prog_serial_out, prog_serial_oe_out, prog_mode_out;
    wire serial_clock_in, prog_serial_in, done;
    wire [31:0] rx;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h9922;
    logic [15:0] pg[4];
    int num_errors = 0;
    int checks_done = 0;
    int n;
    initial forever #25 clk_in = ~clk_in;
    memory_programming_port #(.FLASH_AW(10), .EE_AW(8), .WRITE_CYCLES(18'h12C),
        .ERASE_CYCLES(18'h5DC), .SIG_BYTES(SIG)) i_dut (.*);
    serial_programmer i_prog (.clk_in(clk_in), .miso_in(prog_serial_out),
        .sck_out(serial_clock_in), .mosi_out(prog_serial_in), .done_out(done), .rx_out(rx));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic stop_test;
        if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Mask picks the third-byte echo and/or the fourth-byte reply
    task automatic ser(input logic [31:0] tx, input logic [15:0] m, input logic [15:0] v);
        exp_q.push_back({m, v});
        i_prog.frame(tx);
    endtask
    task automatic wait_lvl(input logic lvl, input int lim);
        n = 0;
        while (ready_busy_flag_out !== lvl) begin
            @(posedge clk_in);
            n++;
            if (n > lim) begin
                num_errors++;
                stop_test();
            end
        end
    endtask
    task automatic pload(input logic [1:0] act, input logic [7:0] d);
        load_action_select_in <= act;
        byte_half_select_in <= 1'b0;
        par_data_in <= d;
        repeat (2) @(posedge clk_in);
        load_strobe_clock_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        load_strobe_clock_in <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
    always @(posedge clk_in) begin
        if (done && exp_q.size() > 0) begin
            chk(rx[15:0] & exp_q[0][31:16], exp_q[0][15:0]);
            void'(exp_q.pop_front());
        end
    end
    initial begin
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        ser(32'hAC800000, 16'hFF00, 16'h8000);
        ser(32'hAC530000, 16'hFF00, 16'h5300);
        chk({15'h0, ready_busy_flag_out}, 16'h1);
        ser(32'hAC800000, 16'hFF00, 16'h8000);
        wait_lvl(1'b0, 50);
        wait_lvl(1'b1, 3000);
        chk({15'h0, n >= 1490 && n <= 2000}, 16'h1);
        ser(32'hA0001000, 16'hFFFF, 16'h00FF);
        for (int w = 0; w < 4; w++) begin
            seed = xs(seed);
            pg[w] = seed[15:0];
            ser({16'h4000, 6'h0, w[1:0], pg[w][7:0]}, 16'hFF00, 16'h0000);
            ser({16'h4800, 6'h0, w[1:0], pg[w][15:8]}, 16'hFF00, 16'h0000);
        end
        ser(32'h4C000000, 16'hFF00, 16'h0000);
        ser(32'h20000100, 16'hFFFF, 16'h00FF);
        wait_lvl(1'b1, 1000);
        for (int w = 0; w < 8; w++)
            ser({4'h2, w[0], 11'h0, 6'h0, w[2:1], 8'h00}, 16'hFFFF,
                {8'h00, w[0] ? pg[w[2:1]][15:8] : pg[w[2:1]][7:0]});
        seed = xs(seed);
        // Second write sets bits the first cleared, so it only lands if erased first
        for (int k = 0; k < 2; k++) begin
            ser({16'hC000, seed[15:8], k ? ~seed[7:0] : seed[7:0]}, 16'hFF00, 16'h0);
            ser({16'hA000, seed[15:8], 8'h00}, 16'hFFFF, 16'h00FF);
            wait_lvl(1'b1, 1000);
            ser({16'hA000, seed[15:8], 8'h00}, 16'hFFFF,
                {8'h00, k ? ~seed[7:0] : seed[7:0]});
        end
        reset_pin_n_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        chk({15'h0, prog_serial_oe_out}, 16'h0);
        chk({15'h0, prog_mode_out}, 16'h0);
        par_mode_in <= 1'b1;
        pload(2'h2, 8'h08);
        for (int a = 0; a < 4; a++) begin
            pload(2'h0, a[7:0]);
            read_drive_n_in <= 1'b0;
            repeat (6) @(posedge clk_in);
            chk({8'h00, par_data_out}, {8'h00, a == 3 ? 8'hFF : SIG[8*a +: 8]});
            byte_half_select_in <= 1'b1;
            repeat (6) @(posedge clk_in);
            chk({8'h00, par_data_out}, 16'h0080);
            read_drive_n_in <= 1'b1;
        end
        pload(2'h2, 8'h10);
        write_strobe_n_in <= 1'b0;
        wait_lvl(1'b0, 20);
        write_strobe_n_in <= 1'b1;
        wait_lvl(1'b1, 500);
        chk({15'h0, n >= 296 && n <= 405}, 16'h1);
        // Strap entry with the reset pin high; only a fresh power-on or parallel mode leaves it
        par_mode_in <= 1'b0;
        program_entry_pin_n_in <= 1'b0;
        nrst_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        chk({14'h0, prog_serial_oe_out, prog_mode_out}, 16'h3);
        ser(32'hAC530000, 16'hFF00, 16'h5300);
        ser(32'h30000000, 16'hFFFF, {8'h00, SIG[7:0]});
        stop_test();
    end
endmodule // memory_programming_port_test
`default_nettype wire
